// ===== core/clk_pkg.sv
// Package of constants and types shared by the codec clock ends.
package clk_pkg;
   localparam int MASTER_RATIO       = 256;
   localparam int FS_DIV             = 256;
   localparam int PLL_POST_DIV       = 4;
   localparam int INT_MIN            = 6;
   localparam int INT_MAX            = 12;
   localparam int FRAC_W             = 24;
   localparam int REG_W              = 9;
   localparam int FRAC_HI_W          = 6;
   localparam int FRAC_MID_LSB       = 9;
   localparam int FRAC_HI_LSB        = 18;
   localparam int MASTER_MAX_KHZ     = 12288;
   localparam int VCO_MIN_MHZ        = 90;
   localparam int VCO_MAX_MHZ        = 100;
   localparam logic [3:0] INT_RESET  = 4'h8;
   localparam logic [2:0] PRE_RESET  = 3'h1;
   localparam logic [2:0] BCLK_RESET = 3'h0;
   localparam logic [1:0] GP_RESET   = 2'h0;
   localparam int SYNC_LEN           = 2;

   typedef enum logic [1:0] {
      FMT_I2S   = 2'b00,
      FMT_LEFT  = 2'b01,
      FMT_PCM   = 2'b10,
      FMT_RIGHT = 2'b11
   } audio_fmt_t;

   typedef enum logic [1:0] {
      MF_DIV1 = 2'b00,
      MF_DIV2 = 2'b01,
      MF_DIV3 = 2'b10,
      MF_DIV4 = 2'b11
   } mf_div_t;

   typedef struct packed {
      logic             pll_en;
      logic             src_pll;
      logic             master;
      logic [2:0]       mclk_pre;
      logic [2:0]       bclk_div;
      audio_fmt_t       fmt;
      logic [2:0]       rate_ind;
      logic             pll_in_div2;
      logic [3:0]       pll_int;
      logic [FRAC_W-1:0] pll_frac;
      logic             mf_route;
      mf_div_t          mf_div;
   } clk_cfg_t;
endpackage

// ===== core/clk_link_if.sv
// Interface joining the codec clock block and the audio party.
`timescale 1ns/1ns
interface clk_link_if;
   import clk_pkg::*;
   clk_cfg_t cfg;
   logic     fs_o;
   logic     fs_oe_n;
   logic     bclk_o;
   logic     bclk_oe_n;
   logic     fs_i;
   logic     bclk_i;
   logic     ref_clk;
   logic     vco_clk;

   modport device (
      input  cfg, fs_i, bclk_i, ref_clk, vco_clk,
      output fs_o, fs_oe_n, bclk_o, bclk_oe_n
   );
   modport host (
      output cfg, fs_i, bclk_i, ref_clk, vco_clk,
      input  fs_o, fs_oe_n, bclk_o, bclk_oe_n
   );
endinterface

// ===== core/codec_clock.sv
// Device end: clock select, prescalers, frame sync and bit clock.
//
// What the document requires
// RULE_01 - Internal master clock is 256 times sample rate.
// RULE_02 - Host keeps master clock at most 12.288MHz.
// RULE_03 - Master clock is source divided by integer.
// RULE_04 - Source is reference pin or PLL output.
// RULE_05 - PLL disabled after reset until enabled.
// RULE_06 - Master frame sync is master clock over 256.
// RULE_07 - Master bit clock via programmable divider.
// RULE_08 - Slave mode: frame sync, bit clock inputs.
// RULE_09 - Far party keeps link clocks synchronous.
// RULE_10 - Sample rate comes only from master clock.
// RULE_11 - Rate indication scales filters, not rate.
// RULE_12 - PLL input prescaler divides by one or two.
// RULE_13 - PLL output fixed divide by four.
// RULE_14 - Host programs integer multiplier six to twelve.
// RULE_15 - Fraction is 24 bits over three registers.
// RULE_16 - Host rounds fraction times two to 24.
// RULE_17 - Input prescaler and integer share one register.
// RULE_18 - PLL clock routable to multi-function pin.
// RULE_19 - Host keeps oscillator between 90 and 100MHz.
// RULE_20 - Pin route divides further by 2, 3, 4.
// RULE_21 - Host writes multipliers with PLL disabled.
// RULE_22 - Fraction split six, nine, nine bits.
// RULE_23 - Source switch without glitches.
`timescale 1ns/1ns
module codec_clock (
   input  wire logic                 CLK,
   input  wire logic                 RST_N,
   clk_link_if.device                LINK,
   output logic                      INTERNAL_MASTER_CLOCK,
   output logic                      SAMPLE_TICK,
   output logic                      PLL_RUN,
   output logic [clk_pkg::REG_W-1:0] FRAC_REG_HI,
   output logic [clk_pkg::REG_W-1:0] FRAC_REG_MID,
   output logic [clk_pkg::REG_W-1:0] FRAC_REG_LO,
   output logic [clk_pkg::REG_W-1:0] PLL_INT_REG,
   output logic [2:0]                FILTER_SCALE,
   output logic                      MULTI_FUNCTION_PIN
);
   import clk_pkg::*;

   // ******************************
   // Synchronisers for slow inputs
   // ******************************
   logic [SYNC_LEN-1:0] ref_sync;
   logic [SYNC_LEN-1:0] vco_sync;
   logic                ref_q;
   logic                vco_q;
   logic                ref_rise;
   logic                vco_rise;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ref_sync <= '0;
         vco_sync <= '0;
         ref_q    <= 1'b0;
         vco_q    <= 1'b0;
      end else begin
         ref_sync <= {ref_sync[0], LINK.ref_clk};
         vco_sync <= {vco_sync[0], LINK.vco_clk};
         ref_q    <= ref_sync[1];
         vco_q    <= vco_sync[1];
      end
   end
   assign ref_rise = ref_sync[1] & ~ref_q;
   assign vco_rise = vco_sync[1] & ~vco_q;

   // ******************************
   // PLL path dividers
   // ******************************
   logic       pll_on;
   logic       in_half;
   logic       pll_tick;
   logic [1:0] post_cnt;
   logic       post_tick;

   assign pll_on = LINK.cfg.pll_en; // RULE_05
   assign PLL_RUN = pll_on;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         in_half <= 1'b0;
      end else if (ref_rise) begin
         in_half <= ~in_half;
      end
   end
   // The oscillator edge is gated to the PLL by the input prescaler.
   assign pll_tick = pll_on & vco_rise &
                     (!LINK.cfg.pll_in_div2 | in_half); // RULE_12

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         post_cnt <= '0;
      end else if (!pll_on) begin
         post_cnt <= '0;
      end else if (pll_tick) begin
         post_cnt <= post_cnt + 2'd1; // RULE_13
      end
   end
   assign post_tick = pll_tick && (post_cnt == 2'(PLL_POST_DIV - 1));

   // ******************************
   // Glitch-free source select
   // ******************************
   logic sel_pll;
   logic src_tick;

   // Select changes only on a reference edge, a post divider tick or while the PLL is off, so no runt event forms.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sel_pll <= 1'b0;
      end else if (ref_rise || post_tick || !pll_on) begin
         sel_pll <= LINK.cfg.src_pll & pll_on; // RULE_23
      end
   end
   assign src_tick = sel_pll ? post_tick : ref_rise; // RULE_04

   // ******************************
   // Master clock prescaler
   // ******************************
   logic [2:0] pre_cnt;
   logic       master_tick;
   logic [2:0] pre_lim;

   assign pre_lim = (LINK.cfg.mclk_pre == 3'h0) ? 3'h1 : LINK.cfg.mclk_pre;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pre_cnt <= '0;
      end else if (src_tick) begin
         if (pre_cnt >= pre_lim - 3'h1) begin
            pre_cnt <= '0; // RULE_03
         end else begin
            pre_cnt <= pre_cnt + 3'h1;
         end
      end
   end
   assign master_tick = src_tick && (pre_cnt >= pre_lim - 3'h1);

   // One high cycle per terminal count gives one master clock period per
   // prescaler period, where a toggle would halve the rate.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         INTERNAL_MASTER_CLOCK <= 1'b0;
      end else begin
         INTERNAL_MASTER_CLOCK <= master_tick; // RULE_01
      end
   end

   // ******************************
   // Frame and bit clock generation
   // ******************************
   logic [7:0] fs_cnt;
   logic [2:0] bclk_cnt;
   logic       bclk_q;
   logic       fs_q;
   logic       next_fs;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         fs_cnt <= '0;
      end else if (master_tick) begin
         fs_cnt <= fs_cnt + 8'h01; // RULE_01
      end
   end
   // Converter rate depends on the master clock count alone.
   assign SAMPLE_TICK = master_tick && (fs_cnt == 8'(FS_DIV - 1)); // RULE_10

   always_comb begin
      case (LINK.cfg.fmt)
         FMT_PCM: next_fs = (fs_cnt < 8'h08);
         FMT_I2S: next_fs = fs_cnt[7];
         default: next_fs = ~fs_cnt[7];
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         fs_q     <= 1'b0;
         bclk_cnt <= '0;
         bclk_q   <= 1'b0;
      end else if (!LINK.cfg.master) begin
         fs_q     <= 1'b0; // RULE_08
         bclk_cnt <= '0;
         bclk_q   <= 1'b0;
      end else if (master_tick) begin
         fs_q <= next_fs; // RULE_06
         if (bclk_cnt >= LINK.cfg.bclk_div) begin
            bclk_cnt <= '0;
            bclk_q   <= ~bclk_q; // RULE_07
         end else begin
            bclk_cnt <= bclk_cnt + 3'h1;
         end
      end
   end
   assign LINK.fs_o      = fs_q;
   assign LINK.bclk_o    = bclk_q;
   assign LINK.fs_oe_n   = ~LINK.cfg.master; // RULE_08
   assign LINK.bclk_oe_n = ~LINK.cfg.master;

   // ******************************
   // Configuration views
   // ******************************
   // Rate indication only steers filter scaling.
   assign FILTER_SCALE = LINK.cfg.rate_ind; // RULE_11
   assign FRAC_REG_HI  = {3'h0, LINK.cfg.pll_frac[FRAC_W-1:FRAC_HI_LSB]}; // RULE_22
   assign FRAC_REG_MID = LINK.cfg.pll_frac[FRAC_HI_LSB-1:FRAC_MID_LSB]; // RULE_15
   assign FRAC_REG_LO  = LINK.cfg.pll_frac[FRAC_MID_LSB-1:0];
   assign PLL_INT_REG  = {4'h0, LINK.cfg.pll_in_div2, LINK.cfg.pll_int}; // RULE_17

   // ******************************
   // Multi-function pin clock
   // ******************************
   logic [2:0] mf_cnt;
   logic [2:0] mf_lim;
   logic       mf_q;

   // The pin follows prescaled oscillator events, so one pin period spans the fixed
   // post divider times the selected ratio, whatever source is selected.
   always_comb begin
      case (LINK.cfg.mf_div)
         MF_DIV2: mf_lim = 3'h3;
         MF_DIV3: mf_lim = 3'h5;
         MF_DIV4: mf_lim = 3'h7;
         default: mf_lim = 3'h1;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mf_cnt <= '0;
         mf_q   <= 1'b0;
      end else if (!LINK.cfg.mf_route) begin
         mf_cnt <= '0;
         mf_q   <= 1'b0;
      end else if (pll_tick) begin
         if (mf_cnt >= mf_lim) begin
            mf_cnt <= '0;
            mf_q   <= ~mf_q; // RULE_20
         end else begin
            mf_cnt <= mf_cnt + 3'h1;
         end
      end
   end
   assign MULTI_FUNCTION_PIN = mf_q; // RULE_18
endmodule

// ===== core/audio_master.sv
// Far end: configures the clock block and supplies slave-mode clocks.
`timescale 1ns/1ns
module audio_master (
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   clk_link_if.host                   LINK,
   input  wire clk_pkg::clk_cfg_t     CFG_IN,
   input  wire logic                  CFG_LOAD,
   output logic                       CFG_REJECT,
   output logic                       FS_SEEN
);
   import clk_pkg::*;

   // ******************************
   // Configuration register
   // ******************************
   clk_cfg_t cfg;
   logic     ok;

   // Multiplier only changes in a load where the PLL was off or is switched off.
   assign ok = (CFG_IN.pll_int >= 4'(INT_MIN)) &&
               (CFG_IN.pll_int <= 4'(INT_MAX)) && // RULE_14
               (!cfg.pll_en || !CFG_IN.pll_en ||
                (CFG_IN.pll_int == cfg.pll_int &&
                 CFG_IN.pll_frac == cfg.pll_frac)); // RULE_21

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg        <= '0;
         cfg.pll_int  <= INT_RESET;
         cfg.mclk_pre <= PRE_RESET;
         CFG_REJECT <= 1'b0;
      end else begin
         CFG_REJECT <= CFG_LOAD & ~ok;
         if (CFG_LOAD && ok) begin
            cfg <= CFG_IN; // RULE_02
         end
      end
   end
   assign LINK.cfg = cfg;

   // ******************************
   // Slave clocks from common reference
   // ******************************
   logic [8:0] div_cnt;
   logic       ref_q;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_cnt <= '0;
         ref_q   <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 9'h001; // RULE_09
         ref_q   <= ~ref_q;
      end
   end
   assign LINK.ref_clk = ref_q;
   assign LINK.vco_clk = ref_q; // RULE_19
   assign LINK.bclk_i  = div_cnt[2];
   assign LINK.fs_i    = div_cnt[8];
   assign FS_SEEN      = LINK.fs_oe_n ? 1'b0 : LINK.fs_o;
endmodule

// ===== verif/codec_clock_monitor.sv
// Concurrent checks on the link between the two clock ends.
`timescale 1ns/1ns
module codec_clock_monitor (
   input wire logic              CLK,
   input wire logic              RST_N,
   input wire clk_pkg::clk_cfg_t cfg,
   input wire logic              fs_o,
   input wire logic              fs_oe_n,
   input wire logic              bclk_oe_n
);
   import clk_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // ***************************************************
   // Cycles since the last format or direction change
   // ***************************************************
   logic [5:0] fmt_age;
   audio_fmt_t fmt_q;
   logic       master_q;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         fmt_age  <= '0;
         fmt_q    <= FMT_I2S;
         master_q <= 1'b0;
      end else begin
         fmt_q    <= cfg.fmt;
         master_q <= cfg.master;
         if (cfg.fmt != fmt_q || cfg.master != master_q) begin
            fmt_age <= '0;
         end else if (fmt_age != 6'h3F) begin
            fmt_age <= fmt_age + 6'h01;
         end
      end
   end
   // ***************************************************
   // Direction, hold and frame sync spacing
   // ***************************************************
   property p_fs_drv;
      $past(cfg.master) && cfg.master |-> !fs_oe_n;
   endproperty
   a_fs_drv: assert property (p_fs_drv) else $error("fs undriven");
   property p_bclk_drv;
      $past(cfg.master) && cfg.master |-> !bclk_oe_n;
   endproperty
   a_bclk_drv: assert property (p_bclk_drv) else $error("bclk undriven");
   property p_fs_in;
      !$past(cfg.master) && !cfg.master |-> fs_oe_n;
   endproperty
   a_fs_in: assert property (p_fs_in) else $error("fs driven");
   property p_bclk_in;
      !$past(cfg.master) && !cfg.master |-> bclk_oe_n;
   endproperty
   a_bclk_in: assert property (p_bclk_in) else $error("bclk driven");
   property p_pll_off;
      $rose(RST_N) |-> !cfg.pll_en;
   endproperty
   a_pll_off: assert property (p_pll_off) else $error("pll on at reset");
   property p_int_rng;
      cfg.pll_int >= INT_MIN && cfg.pll_int <= INT_MAX;
   endproperty
   a_int_rng: assert property (p_int_rng) else $error("bad integer");
   property p_frac_hold;
      $past(cfg.pll_en) && cfg.pll_en |->
         $stable(cfg.pll_frac) && $stable(cfg.pll_int);
   endproperty
   a_frac_hold: assert property (p_frac_hold) else $error("pll word moved");
   property p_fs_hold;
      cfg.master && fmt_age == 6'h3F && $changed(fs_o) |=>
         ($stable(fs_o) || fmt_age != 6'h3F) [*7];
   endproperty
   a_fs_hold: assert property (p_fs_hold) else $error("fs too short");
   c_master: cover property (cfg.master && !fs_oe_n);
   c_pll: cover property ($past(cfg.pll_en) && cfg.pll_en);
   c_fs: cover property (cfg.master && $rose(fs_o));
endmodule

// ===== verif/codec_clock_and_pll_setup_tb.sv
// Self-checking bench joining the clock block and the audio party.
`timescale 1ns/1ns
module codec_clock_and_pll_setup_tb;
   import clk_pkg::*;
   logic        CLK;
   logic        RST_N;
   clk_cfg_t    cfg_in;
   clk_cfg_t    cur;
   logic        cfg_load;
   logic        cfg_reject;
   logic        master_clk;
   logic        fs_seen;
   logic        tick;
   logic        pll_run;
   logic        mf_pin;
   logic [8:0]  fr_hi;
   logic [8:0]  fr_mid;
   logic [8:0]  fr_lo;
   logic [8:0]  int_reg;
   logic [2:0]  fscale;
   logic [31:0] seed;
   int          n_fail;
   int          samples_checked;
   int          n;

   clk_link_if link ();
   codec_clock codec_clock_inst (.CLK(CLK), .RST_N(RST_N), .LINK(link),
      .INTERNAL_MASTER_CLOCK(master_clk), .SAMPLE_TICK(tick),
      .PLL_RUN(pll_run), .FRAC_REG_HI(fr_hi), .FRAC_REG_MID(fr_mid),
      .FRAC_REG_LO(fr_lo),
      .PLL_INT_REG(int_reg), .FILTER_SCALE(fscale),
      .MULTI_FUNCTION_PIN(mf_pin));
   audio_master audio_master_inst (.CLK(CLK), .RST_N(RST_N), .LINK(link),
      .CFG_IN(cfg_in), .CFG_LOAD(cfg_load), .CFG_REJECT(cfg_reject),
      .FS_SEEN(fs_seen));
   codec_clock_monitor codec_clock_monitor_inst (.CLK(CLK), .RST_N(RST_N),
      .cfg(link.cfg), .fs_o(link.fs_o), .fs_oe_n(link.fs_oe_n),
      .bclk_oe_n(link.bclk_oe_n));

   // ***************************************************
   // Helpers
   // ***************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // A load is refused for a bad integer or a word change with PLL held on.
   function automatic logic bad(input clk_cfg_t c, input clk_cfg_t o);
      return c.pll_int < INT_MIN || c.pll_int > INT_MAX || (o.pll_en
         && c.pll_en && {c.pll_int, c.pll_frac} != {o.pll_int, o.pll_frac});
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string m);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask

   task automatic test_done;
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic step(input clk_cfg_t c);
      logic rej;
      logic exp;
      exp = bad(c, cur);
      @(posedge CLK);
      cfg_in <= c;
      cfg_load <= 1'b1;
      @(posedge CLK);
      cfg_load <= 1'b0;
      #1 rej = cfg_reject;
      @(posedge CLK);
      #1 rej = rej | cfg_reject;
      check(rej, exp, "reject flag");
      if (!exp)
         cur = c;
      @(posedge CLK);
      #1 check(pll_run, cur.pll_en, "pll enable");
      check(int_reg, {cur.pll_in_div2, cur.pll_int}, "int reg");
      check(fr_hi, cur.pll_frac[23:18], "frac high");
      check(fr_mid, cur.pll_frac[17:9], "frac mid");
      check(fr_lo, cur.pll_frac[8:0], "frac low");
      check(fscale, cur.rate_ind, "rate scale");
      check(link.fs_oe_n, !cur.master, "fs direction");
      check(link.bclk_oe_n, !cur.master, "bclk direction");
      check(fs_seen, cur.master & link.fs_o, "frame seen");
   endtask

   // Counts rises of one signal over one period of another.
   task automatic ratio(input int sel, output int k);
      logic a, b, pa, pb;
      int   seen;
      k = 0;
      seen = 0;
      pa = 1'b1;
      pb = 1'b1;
      for (int i = 0; i < 20000 && seen < 2; i++) begin
         @(posedge CLK);
         #1 a = (sel == 1 || sel == 4) ? link.vco_clk : master_clk;
         case (sel)
            1: b = mf_pin;
            2: b = link.bclk_o;
            3: b = link.fs_o;
            4: b = master_clk;
            default: b = tick;
         endcase
         if (seen == 1 && a && !pa)
            k++;
         if (b && !pb)
            seen++;
         pa = a;
         pb = b;
      end
      if (seen < 2) begin
         n_fail++;
         test_done;
      end
   endtask

   // ***************************************************
   // Stimulus
   // ***************************************************
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   initial begin
      clk_cfg_t    c;
      logic [63:0] r;
      RST_N = 1'b0;
      cfg_in = '0;
      cfg_load = 1'b0;
      seed = 32'h56;
      n_fail = 0;
      samples_checked = 0;
      cur = '0;
      cur.pll_int = INT_RESET;
      cur.mclk_pre = PRE_RESET;
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      c = cur;
      for (int v = 4; v < 15; v++) begin
         c.pll_int = 4'(v);
         step(c);
      end
      c = cur;
      c.pll_en = 1'b1;
      step(c);
      c.pll_frac = c.pll_frac ^ 24'h3126E9;
      step(c);
      c.pll_en = 1'b0;
      step(c);
      for (int f = 0; f < 4; f++) begin
         c = cur;
         c.master = 1'b1;
         c.fmt = audio_fmt_t'(f);
         c.src_pll = 1'b0;
         c.mclk_pre = 3'h1;
         c.bclk_div = 3'(f);
         step(c);
         ratio(0, n);
         check(n, MASTER_RATIO, "clocks per sample");
         ratio(3, n);
         check(n, FS_DIV, "clocks per frame");
         ratio(2, n);
         check(n, 2 * (f + 1), "clocks per bit clock");
      end
      c.master = 1'b0;
      step(c);
      c.pll_en = 1'b1;
      c.mf_route = 1'b1;
      for (int d = 0; d < 4; d++) begin
         c.mf_div = mf_div_t'(d);
         c.src_pll = 1'b1;
         c.mclk_pre = 3'(d + 1);
         step(c);
         ratio(1, n);
         check(n, PLL_POST_DIV * (d + 1), "pin divide");
         ratio(4, n);
         check(n, PLL_POST_DIV * (d + 1), "osc per master");
      end
      c.pll_in_div2 = 1'b1;
      step(c);
      ratio(4, n);
      check(n, 2 * PLL_POST_DIV * 4, "input prescale");
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         r[63:32] = seed;
         seed = xs(seed);
         r[31:0] = seed;
         c = r[$bits(clk_cfg_t)-1:0];
         c.master = cur.master;
         c.fmt = cur.fmt;
         step(c);
      end
      test_done;
   end
endmodule
